// File: logic/icc_capture.sv
// Input capture channel zero: edge detect, flag, timer clear, registers, interrupt.
// Assumes a byte register port and a pin asynchronous to clk_i.
// A pin pulse seen by fewer than two samples never reaches the edge detector, filter or not.
// Timer 0 itself sits outside; t0_clear_o is only its clear request.
// Reset should last four clocks or more so that the synchroniser is flushed.
// Reserved edge code 11 is stored as written but captures nothing.
//
// Summary of operation
// (RULE_01) Edge select 00 captures rising, 01 falling, 10 either edge, and 11 is reserved.
// (RULE_02) The edge select sits in bits 3:2 of the edge config register; other bits are reserved.
// (RULE_03) With the timer clear bit (bit 6 of option control) set, each capture pulses a Timer 0 clear.
// (RULE_04) With the timer clear bit zero, a capture leaves Timer 0 alone.
// (RULE_05) Bit 3 of option control enables the input noise filter; when clear the input goes unfiltered.
// (RULE_06) A qualifying edge sets the event flag, bit 0 of option control, one clock after detection; the code sets it two clocks after.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module icc_capture
  import icc_pkg::*;
(
  input  wire logic       clk_i,      // System clock 20 MHz
  input  wire logic       rst_n_i,    // Synchronous reset, low
  input  wire logic [7:0] addr_i,     // Register address
  input  wire logic [7:0] wdata_i,    // Write data
  input  wire logic       wr_i,       // Write strobe
  input  wire logic       rd_i,       // Read strobe
  output logic      [7:0] rdata_o,    // Read data, next cycle
  input  wire logic       cap_pin_i,  // Capture pin
  output logic            capture_o,  // Capture pulse
  output logic            t0_clear_o, // Timer 0 clear pulse
  output logic            irq_o       // Interrupt level
);
  icc_bus_req_s req;
  logic [7:0]   edge_cfg_q;
  logic         timer_clear_on_capture_q;
  logic         filt_en_q;
  logic         flag_q;
  logic         mask_q;
  logic         level;
  logic         level_q;
  logic         hit;
  logic         hit_q;
  icc_edge_e    sel;

  // Decode a register write
  function automatic logic wr_hit(input icc_bus_req_s r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign sel = icc_edge_e'(edge_cfg_q[`ICC_EDGE_SEL_HI:`ICC_EDGE_SEL_LO]);

  // Pin synchroniser and filter
  // (RULE_05) filter enable bit
  icc_filter u_filter (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (cap_pin_i),
    .filt_en_i (filt_en_q),
    .level_o   (level)
  );

  // Previous level for edge detection
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level;
    end
  end

  // (RULE_01) edge qualification
  always_comb begin
    case (sel)
      ICC_EDGE_RISE:   hit = level & ~level_q;
      ICC_EDGE_FALL:   hit = ~level & level_q;
      ICC_EDGE_EITHER: hit = level ^ level_q;
      default:         hit = 1'b0;
    endcase
  end

  // (RULE_06) detect registered into hit_q; flag set two clocks after detect
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit;
    end
  end

  // (RULE_02) edge config register, reserved bits held zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      edge_cfg_q <= `ICC_RST_EDGE_CFG;
    end else if (wr_hit(req, `ICC_ADDR_EDGE_CFG)) begin
      edge_cfg_q <= wdata_i & 8'h0c;
    end
  end

  // Option control bits and mask
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      timer_clear_on_capture_q    <= 1'b0;
      filt_en_q <= 1'b0;
      mask_q    <= 1'b0;
    end else begin
      if (wr_hit(req, `ICC_ADDR_OPT_CTRL)) begin
        timer_clear_on_capture_q    <= wdata_i[`ICC_BIT_TIMER_CLEAR_ON_CAPTURE];
        filt_en_q <= wdata_i[`ICC_BIT_FILT_EN];
      end
      if (wr_hit(req, `ICC_ADDR_IRQ_MASK)) begin
        mask_q <= wdata_i[`ICC_BIT_FLAG];
      end
    end
  end

  // (RULE_06) sticky flag, write one clears, set wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_q <= 1'b0;
    end else if (hit_q) begin
      flag_q <= 1'b1;
    end else if (wr_hit(req, `ICC_ADDR_OPT_CTRL) && wdata_i[`ICC_BIT_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // Capture and timer clear pulses
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      capture_o  <= 1'b0;
      t0_clear_o <= 1'b0;
    end else begin
      capture_o  <= hit_q;
      // (RULE_03) clear Timer 0 on capture
      // (RULE_04) no clear when bit is zero
      t0_clear_o <= hit_q & timer_clear_on_capture_q;
    end
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        `ICC_ADDR_EDGE_CFG: rdata_o <= edge_cfg_q;
        `ICC_ADDR_OPT_CTRL: rdata_o <= {1'b0, timer_clear_on_capture_q, 2'h0, filt_en_q, 2'h0, flag_q};
        `ICC_ADDR_IRQ_MASK: rdata_o <= {7'h00, mask_q};
        default:            rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Interrupt level
  assign irq_o = flag_q & mask_q;

  // (RULE_06) flag follows detection
  chk_flag_after_hit: assert property (@(posedge clk_i) disable iff (!rst_n_i) hit |=> ##1 flag_q) // RULE_06
    else $error("flag not set after edge");

  // (RULE_03) clear follows capture
  chk_clear_on_cap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hit_q && timer_clear_on_capture_q |=> t0_clear_o) // RULE_03
    else $error("timer clear missing");

  // (RULE_04) no clear when disabled
  chk_no_clear_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    t0_clear_o |-> $past(timer_clear_on_capture_q)) // RULE_04
    else $error("timer cleared while disabled");

  // (RULE_01) rising only in rising mode
  chk_rise_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hit && sel == ICC_EDGE_RISE |-> level && !level_q) // RULE_01
    else $error("rising mode wrong edge");

  // (RULE_01) falling only in falling mode
  chk_fall_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hit && sel == ICC_EDGE_FALL |-> !level && level_q) // RULE_01
    else $error("falling mode wrong edge");

  // (RULE_01) reserved code never fires
  chk_rsvd_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sel == ICC_EDGE_RSVD |-> !hit) // RULE_01
    else $error("reserved code triggered");

  // (RULE_02) reserved bits stay zero
  chk_rsvd_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (edge_cfg_q & 8'hf3) == 8'h00) // RULE_02
    else $error("reserved config bits set");

  // (RULE_05) filter follows written bit
  chk_filt_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_hit(req, `ICC_ADDR_OPT_CTRL) |=> filt_en_q == $past(wdata_i[`ICC_BIT_FILT_EN])) // RULE_05
    else $error("filter enable not stored");

  // (RULE_06) capture pulse follows detection
  chk_cap_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_06
    hit_q |=> capture_o)
    else $error("capture pulse missing");

  // (RULE_06) capture pulse has a cause
  chk_cap_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_06
    capture_o |-> $past(hit_q))
    else $error("capture pulse without edge");

  // (RULE_06) flag set by a delayed hit
  chk_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_06
    hit_q |=> flag_q)
    else $error("flag not set by capture");

  // (RULE_06) write one clears the flag
  chk_flag_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_06
    flag_q && !hit_q && wr_hit(req, `ICC_ADDR_OPT_CTRL) && wdata_i[`ICC_BIT_FLAG] |=> !flag_q)
    else $error("flag not cleared");

  // (RULE_06) flag is sticky
  chk_flag_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_06
    flag_q && !(wr_hit(req, `ICC_ADDR_OPT_CTRL) && wdata_i[`ICC_BIT_FLAG]) |=> flag_q)
    else $error("flag dropped without clear");

  // (RULE_06) interrupt needs an unmasked flag
  chk_irq_needs_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_06
    irq_o |-> flag_q && mask_q)
    else $error("interrupt without unmasked flag");

  // (RULE_06) mask follows written bit
  chk_mask_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_06
    wr_hit(req, `ICC_ADDR_IRQ_MASK) |=> mask_q == $past(wdata_i[`ICC_BIT_FLAG]))
    else $error("mask not stored");

  // (RULE_03) clear only beside a capture
  chk_clear_with_cap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_03
    t0_clear_o |-> capture_o)
    else $error("timer clear without capture");

  // (RULE_04) capture with bit zero leaves timer
  chk_no_clear_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_04
    hit_q && !timer_clear_on_capture_q |=> !t0_clear_o)
    else $error("timer cleared with bit zero");

  // (RULE_03) timer clear bit follows write
  chk_timer_clear_on_capture_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_03
    wr_hit(req, `ICC_ADDR_OPT_CTRL) |=> timer_clear_on_capture_q == $past(wdata_i[`ICC_BIT_TIMER_CLEAR_ON_CAPTURE]))
    else $error("timer clear bit not stored");

  // (RULE_01) rising mode catches every rise
  chk_rise_hit: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_01
    sel == ICC_EDGE_RISE && level && !level_q |-> hit)
    else $error("rising edge missed");

  // (RULE_01) falling mode catches every fall
  chk_fall_hit: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_01
    sel == ICC_EDGE_FALL && !level && level_q |-> hit)
    else $error("falling edge missed");

  // (RULE_01) either mode catches both
  chk_either_hit: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_01
    sel == ICC_EDGE_EITHER && (level != level_q) |-> hit)
    else $error("edge missed in either mode");

  // (RULE_01) reserved code leaves no delayed hit
  chk_rsvd_no_cap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_01
    sel == ICC_EDGE_RSVD |=> !hit_q)
    else $error("reserved code captured");

  // (RULE_02) edge field follows write
  chk_edge_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_02
    wr_hit(req, `ICC_ADDR_EDGE_CFG) |=> edge_cfg_q[3:2] == $past(wdata_i[3:2]))
    else $error("edge select not stored");

  // (RULE_02) edge config reads back
  chk_cfg_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_02
    rd_i && addr_i == `ICC_ADDR_EDGE_CFG |=> rdata_o == $past(edge_cfg_q))
    else $error("edge config read wrong");

  // (RULE_05) filter bit reads back
  chk_filt_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_05
    rd_i && addr_i == `ICC_ADDR_OPT_CTRL |=> rdata_o[`ICC_BIT_FILT_EN] == $past(filt_en_q))
    else $error("filter bit read wrong");

  // (RULE_03) timer clear bit reads back
  chk_timer_clear_on_capture_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_03
    rd_i && addr_i == `ICC_ADDR_OPT_CTRL |=> rdata_o[`ICC_BIT_TIMER_CLEAR_ON_CAPTURE] == $past(timer_clear_on_capture_q))
    else $error("timer clear bit read wrong");

  // Read data idle between reads
  chk_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");

  // Unmapped reads return zero
  chk_unmapped_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i != `ICC_ADDR_EDGE_CFG && addr_i != `ICC_ADDR_OPT_CTRL && addr_i != `ICC_ADDR_IRQ_MASK
    |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // Outputs quiet through reset
  chk_reset_quiet: assert property (@(posedge clk_i)
    !rst_n_i |=> !flag_q && !capture_o && !t0_clear_o && rdata_o == 8'h00)
    else $error("outputs active in reset");
endmodule
`default_nettype wire

// File: logic/icc_filter.sv
// Three-stage pin synchroniser with an optional noise filter.
// Assumes a single clock; the pin is asynchronous to it.
`timescale 1ns/1ps
`default_nettype none
module icc_filter
  import icc_pkg::*;
(
  input  wire logic clk_i,     // System clock
  input  wire logic rst_n_i,   // Synchronous reset, low
  input  wire logic pin_i,     // Raw capture pin
  input  wire logic filt_en_i, // Filter enable
  output logic      level_o    // Cleaned level
);
  localparam int unsigned FILT_N = `ICC_FILT_CYCLES;

  logic [2:0] sync_q;
  logic [1:0] cnt_q;
  logic       stable_q;

  // Three flops; a change counts once the last two agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], pin_i};
    end
  end

  // Filter: new level must hold for FILT_N agreeing samples
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q    <= 2'h0;
      stable_q <= 1'b0;
    end else if (sync_q[2] != sync_q[1] || sync_q[2] == stable_q) begin
      cnt_q <= 2'h0;
    end else if (cnt_q == 2'(FILT_N - 1)) begin
      cnt_q    <= 2'h0;
      stable_q <= sync_q[2];
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // Bypass when filter is off
  always_comb begin
    if (filt_en_i) begin
      level_o = stable_q;
    end else begin
      level_o = (sync_q[2] == sync_q[1]) ? sync_q[2] : stable_q;
    end
  end
endmodule
`default_nettype wire

// File: logic/icc_pkg.sv
// Types shared by the capture channel modules.
// Assumes the register header sits beside it.
`default_nettype none
package icc_pkg;
  `include "icc_regs.svh"

  // Edge select encodings
  typedef enum logic [1:0] {
    ICC_EDGE_RISE   = 2'h0,
    ICC_EDGE_FALL   = 2'h1,
    ICC_EDGE_EITHER = 2'h2,
    ICC_EDGE_RSVD   = 2'h3
  } icc_edge_e;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } icc_bus_req_s;
endpackage
`default_nettype wire

// File: logic/icc_regs.svh
// Register offsets, field positions, reset values and timing counts for the capture channel.
// Assumes inclusion by bare name from the package or design files.
`ifndef ICC_REGS_SVH
`define ICC_REGS_SVH

`define ICC_ADDR_EDGE_CFG   8'ha3
`define ICC_ADDR_OPT_CTRL   8'ha4
`define ICC_ADDR_IRQ_MASK   8'ha5
`define ICC_EDGE_SEL_HI     3
`define ICC_EDGE_SEL_LO     2
`define ICC_BIT_TIMER_CLEAR_ON_CAPTURE        6
`define ICC_BIT_FILT_EN     3
`define ICC_BIT_FLAG        0
`define ICC_RST_EDGE_CFG    8'h00
`define ICC_RST_OPT_CTRL    8'h00
`define ICC_RST_IRQ_MASK    8'h00
`define ICC_FILT_TIME_NS    150
`define ICC_CLK_PERIOD_NS   50
`define ICC_FILT_CYCLES     ((`ICC_FILT_TIME_NS + `ICC_CLK_PERIOD_NS - 1) / `ICC_CLK_PERIOD_NS)

`endif

// File: sim/icc_capture_tb.sv
// Self-checking bench for the capture channel: registers, edges, filter, timer clear, interrupt.
// Assumes icc_pkg, icc_capture and icc_pin_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module icc_capture_tb;
  import icc_pkg::*;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, rd_q = 0, want = 0, glit = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, opt;
  logic       cap, clr, irq, pin, expf;
  int         bad_count = 0, check_count = 0, ncap = 0, nclr = 0;
  logic [7:0] expq[$];

  // Clock of 50 ns
  always #25 clk = ~clk;

  icc_capture uut (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .cap_pin_i(pin), .capture_o(cap), .t0_clear_o(clr), .irq_o(irq));
  icc_pin_model pm (.clk_i(clk), .level_i(want), .spike_i(glit), .pin_o(pin));

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [7:0] a, logic [7:0] e);
    expq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic irq_step(logic [7:0] a, logic [7:0] d, logic e);
    wr_reg(a, d);
    @(posedge clk);
    check("irq", {7'h0, e}, {7'h0, irq});
  endtask

  // Monitor: count pulses, compare read data with the oldest note
  always @(posedge clk) begin
    rd_q <= rd;
    if (cap === 1'b1) ncap++;
    if (clr === 1'b1) nclr++;
    if (rd_q) check("rdata", expq.pop_front(), rdata);
  end

  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial begin : main
    void'($urandom(14));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 8'ha3; a <= 8'ha6; a++) rd_reg(a[7:0], 8'h00);
    opt = {4'h0, 2'($urandom_range(2, 0)), 2'h0};
    wr_reg(8'ha3, opt);
    rd_reg(8'ha3, opt);
    // Every edge code against rise and fall, timer clear on odd codes
    for (int c = 0; c < 4; c++) begin
      for (int d = 1; d >= 0; d--) begin
        wr_reg(8'ha3, {4'h0, c[1:0], 2'h0});
        wr_reg(8'ha4, {1'b0, c[0], 6'h01});
        ncap = 0;
        nclr = 0;
        want <= d[0];
        repeat (14) @(posedge clk);
        expf = (c == 2) || (c == 1 - d);
        check("captures", {7'h0, expf}, ncap[7:0]);
        check("clears", {7'h0, expf & c[0]}, nclr[7:0]);
        rd_reg(8'ha4, {1'b0, c[0], 5'h00, expf});
      end
    end
    // Interrupt: raise, mask, unmask, clear
    wr_reg(8'ha3, 8'h00);
    irq_step(8'ha5, 8'h01, 1'b0);
    want <= 1'b1;
    repeat (14) @(posedge clk);
    check("irq", 8'h01, {7'h0, irq});
    irq_step(8'ha5, 8'h00, 1'b0);
    irq_step(8'ha5, 8'h01, 1'b1);
    irq_step(8'ha4, 8'h01, 1'b0);
    // Two-cycle spike, filter off then on, either-edge code
    for (int f = 0; f < 2; f++) begin
      wr_reg(8'ha3, 8'h08);
      wr_reg(8'ha4, {4'h0, f[0], 3'h1});
      ncap = 0;
      glit <= 1'b1;
      repeat (2) @(posedge clk);
      glit <= 1'b0;
      repeat (14) @(posedge clk);
      check("spike", f ? 8'h00 : 8'h02, ncap[7:0]);
    end
    end_sim();
  end
endmodule
`default_nettype wire

// File: sim/icc_pin_model.sv
// Far-side driver of the capture pin: a held level plus a spike input.
// Assumes the bench steers level_i and spike_i on clock edges.
`timescale 1ns/1ps
`default_nettype none
module icc_pin_model (
  input  wire logic clk_i,   // Bench clock
  input  wire logic level_i, // Wanted pin level
  input  wire logic spike_i, // Invert the level while high
  output var logic  pin_o = 1'b0 // Pin seen by the block
);
  // Pin follows the wanted level, inverted during a spike
  always @(posedge clk_i) begin
    pin_o <= level_i ^ spike_i;
  end
endmodule
`default_nettype wire
